// [inc/vanc_pkg.sv]
// package: register map, stream carriers, formats and helpers for the vanc insert control
package vanc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_WINDOW  = 8'h04;
  localparam logic [7:0]  OFS_SERVICE = 8'h08;
  localparam logic [7:0]  OFS_LENGTH  = 8'h0C;
  localparam logic [7:0]  OFS_LOAD    = 8'h10;
  localparam logic [7:0]  OFS_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_LABEL   = 8'h18;

  // ctrl fields
  localparam int          CTRL_ACTIVE_BIT = 0;
  localparam int          CTRL_POL_LSB    = 1;
  localparam int          CTRL_PRIO_BIT   = 3;
  localparam int          CTRL_625_BIT    = 4;
  localparam int          CTRL_BD_LSB     = 5;
  // window, service, load fields
  localparam int          WIN_FIRST_LSB   = 0;
  localparam int          WIN_LAST_LSB    = 16;
  localparam int          SVC_DID_LSB     = 0;
  localparam int          SVC_SDID_LSB    = 8;
  localparam int          SVC_LINE_LSB    = 16;
  localparam int          LOAD_DATA_LSB   = 0;
  localparam int          LOAD_IDX_LSB    = 16;

  // insertion policies
  localparam logic [1:0]  POL_APPEND    = 2'h0;
  localparam logic [1:0]  POL_PREPEND   = 2'h1;
  localparam logic [1:0]  POL_OVERWRITE = 2'h2;

  // menu backdrop selections
  localparam logic [2:0]  BD_BLACK   = 3'h0;
  localparam logic [2:0]  BD_GREY    = 3'h1;
  localparam logic [2:0]  BD_WHITE   = 3'h2;
  localparam logic [2:0]  BD_BLUE    = 3'h3;
  localparam logic [2:0]  BD_OVERLAY = 3'h4;

  // reset values
  localparam logic [31:0] RST_CTRL    = 32'h0000_0001;
  localparam logic [10:0] RST_FIRST   = 11'h001;
  localparam logic [10:0] RST_LAST    = 11'h014;
  localparam logic [31:0] RST_SERVICE = 32'h0009_0000;

  // capture window ceilings
  localparam logic [10:0] WIN_LAST_PROG = 11'h019;
  localparam logic [10:0] WIN_LAST_STD  = 11'h014;

  // backdrop colours, 10-bit Y/Cb/Cr
  localparam logic [29:0] YCC_BLACK = {10'h040, 10'h200, 10'h200};
  localparam logic [29:0] YCC_GREY  = {10'h1F8, 10'h200, 10'h200};
  localparam logic [29:0] YCC_WHITE = {10'h3AC, 10'h200, 10'h200};
  localparam logic [29:0] YCC_BLUE  = {10'h0A6, 10'h3C0, 10'h1D6};

  typedef enum logic [3:0] {
    FMT_NONE, FMT_480I_5994, FMT_576I_50, FMT_720P_50, FMT_720P_5994,
    FMT_1080I_50, FMT_1080I_5994, FMT_1080P_2398, FMT_1080SF_2398
  } fmt_e;

  // one incoming stream beat
  typedef struct packed {
    logic        valid;
    logic        field_first;
    logic        line_last;
    logic        is_anc;
    logic        pkt_first;
    logic [10:0] line_num;
    logic [7:0]  did;
    logic [7:0]  sdid;
    logic [9:0]  data;
  } vid_beat_s;

  // one outgoing stream beat
  typedef struct packed {
    logic        valid;
    logic        line_last;
    logic        is_anc;
    logic        is_local;
    logic [10:0] line_num;
    logic [9:0]  data;
  } out_beat_s;

  // settings that are frozen per field
  typedef struct packed {
    logic        active;
    logic [1:0]  pol;
    logic        local_prio;
    logic [10:0] first;
    logic [10:0] last;
  } ins_cfg_s;

  // last line of the vertical interval for a format
  function automatic logic [10:0] vi_last_line(input fmt_e f);
    case (f)
      FMT_720P_50, FMT_720P_5994, FMT_1080SF_2398: vi_last_line = WIN_LAST_PROG;
      default:                                     vi_last_line = WIN_LAST_STD;
    endcase
  endfunction : vi_last_line

  function automatic logic is_sd(input fmt_e f);
    is_sd = (f == FMT_480I_5994) || (f == FMT_576I_50);
  endfunction : is_sd

endpackage : vanc_pkg

// [logic/anc_dup_match.sv]
// comparator: flags an incoming packet whose DID/SDID equals the local service
module anc_dup_match (
  // incoming packet identity
  input  wire logic       en_i,
  input  wire logic [7:0] did_i,
  input  wire logic [7:0] sdid_i,
  // local service identity
  input  wire logic [7:0] svc_did_i,
  input  wire logic [7:0] svc_sdid_i,
  // result
  output logic            match_o
);

  // both bytes must agree; a bare DID match is a different service
  always_comb begin
    match_o = en_i && (did_i == svc_did_i) && (sdid_i == svc_sdid_i);
  end

endmodule : anc_dup_match

// [logic/menu_backdrop.sv]
// menu raster and backdrop colour / key selection
module menu_backdrop
  import vanc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // settings and input format
  input  wire logic [2:0]  sel_i,
  input  wire logic        raster_625_i,
  input  wire fmt_e        fmt_i,
  // menu outputs
  output logic             key_o,
  output logic             raster_625_o,
  output logic [29:0]      colour_o
);

  logic        next_key;
  logic [29:0] next_colour;

  // overlay keys only over sd video; otherwise it falls back to black
  always_comb begin
    next_key    = 1'b0;
    next_colour = YCC_BLACK;
    case (sel_i)
      BD_GREY:    next_colour = YCC_GREY;
      BD_WHITE:   next_colour = YCC_WHITE;
      BD_BLUE:    next_colour = YCC_BLUE;
      BD_OVERLAY: next_key    = is_sd(fmt_i);
      default:    next_colour = YCC_BLACK;
    endcase
  end

  // registered so the menu renderer sees stable values
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_o        <= 1'b0;
      raster_625_o <= 1'b0;
      colour_o     <= YCC_BLACK;
    end else begin
      key_o        <= next_key;
      raster_625_o <= raster_625_i;
      colour_o     <= next_colour;
    end
  end

endmodule : menu_backdrop

// [logic/vanc_insert_mode_control.sv]
// top: per-line ancillary packet merge, capture window and register port
module vanc_insert_mode_control
  import vanc_pkg::*;
#(
  parameter int BUF_DEPTH = 64,
  parameter int LOC_DEPTH = 32,
  parameter int LINE_CAP  = 96
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // incoming video
  input  wire vid_beat_s   in_beat_i,
  input  wire fmt_e        in_fmt_i,
  output logic             in_ready_o,
  // outgoing video
  output out_beat_s        out_beat_o,
  // captured packet words
  output logic             cap_valid_o,
  output logic [9:0]       cap_data_o,
  output logic [10:0]      cap_line_o,
  // menu look
  output logic             menu_key_o,
  output logic             menu_raster_standard_o,
  output logic [29:0]      menu_backdrop_colour_o
);

  localparam int BW = $clog2(BUF_DEPTH) + 1;
  localparam int LW = $clog2(LOC_DEPTH) + 1;
  localparam logic [BW:0] CAP_W = (BW + 1)'(LINE_CAP);
  localparam logic [BW-1:0] DEPTH_W = BW'(BUF_DEPTH);

  typedef enum logic [1:0] {S_FILL, S_EMIT_A, S_EMIT_B, S_MARK} state_e;

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] window, next_window;
  logic [31:0] service, next_service;
  logic [LW-1:0] loc_len, next_loc_len;
  logic [31:0] card_label, next_card_label;
  logic [31:0] next_rdata;
  logic        loc_we;
  logic [LW-2:0] loc_widx;
  logic [9:0]  loc_mem [LOC_DEPTH];
  logic [9:0]  buf_mem [BUF_DEPTH];

  logic        ovf, next_ovf;
  logic        match_seen, next_match_seen;
  logic [31:0] status_word;

  // register writes; reads of unmapped offsets return zero
  always_comb begin
    next_ctrl       = ctrl;
    next_window     = window;
    next_service    = service;
    next_loc_len    = loc_len;
    next_card_label = card_label;
    loc_we          = 1'b0;
    loc_widx        = reg_wdata_i[LOAD_IDX_LSB +: LW-1];
    next_rdata      = 32'h0000_0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_CTRL:    next_ctrl       = reg_wdata_i;
        OFS_WINDOW:  next_window     = reg_wdata_i;
        OFS_SERVICE: next_service    = reg_wdata_i;
        OFS_LENGTH:  next_loc_len    = reg_wdata_i[LW-1:0];
        OFS_LOAD:    loc_we          = 1'b1;
        OFS_LABEL:   next_card_label = reg_wdata_i;
        default:     loc_we          = 1'b0;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL:    next_rdata = ctrl;
        OFS_WINDOW:  next_rdata = window;
        OFS_SERVICE: next_rdata = service;
        OFS_LENGTH:  next_rdata = 32'(loc_len);
        OFS_STATUS:  next_rdata = status_word;
        OFS_LABEL:   next_rdata = card_label;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl        <= RST_CTRL;
      window      <= {5'h00, RST_LAST, 5'h00, RST_FIRST};
      service     <= RST_SERVICE;
      loc_len     <= '0;
      card_label  <= 32'h0000_0000;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      ctrl        <= next_ctrl;
      window      <= next_window;
      service     <= next_service;
      loc_len     <= next_loc_len;
      card_label  <= next_card_label;
      reg_rdata_o <= next_rdata;
    end
  end

  // local packet words; no reset needed, length gates their use
  always_ff @(posedge core_clk_i) begin
    if (loc_we) begin
      loc_mem[loc_widx] <= reg_wdata_i[LOAD_DATA_LSB +: 10];
    end
  end

  // ************************************************************
  // field-frozen settings
  // ************************************************************
  ins_cfg_s cfg, next_cfg, eff_cfg, reg_cfg;
  state_e   state, next_state;
  logic     take;

  assign reg_cfg = '{active:     ctrl[CTRL_ACTIVE_BIT],
                     pol:        ctrl[CTRL_POL_LSB +: 2],
                     local_prio: ctrl[CTRL_PRIO_BIT],
                     first:      window[WIN_FIRST_LSB +: 11],
                     last:       window[WIN_LAST_LSB +: 11]};

  assign in_ready_o = (state == S_FILL);
  assign take       = in_beat_i.valid && in_ready_o;

  // a field's first beat picks up the software view, so no line mixes settings
  always_comb begin
    next_cfg = cfg;
    eff_cfg  = cfg;
    if (take && in_beat_i.field_first) begin
      next_cfg = reg_cfg;
      eff_cfg  = reg_cfg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ************************************************************
  // capture window
  // ************************************************************
  logic [10:0] win_last;
  logic        next_cap_valid;

  // the end line is clamped to the vertical interval ceiling of the input format
  always_comb begin
    win_last = eff_cfg.last;
    if (win_last > vi_last_line(in_fmt_i)) begin
      win_last = vi_last_line(in_fmt_i);
    end
    next_cap_valid = take && in_beat_i.is_anc &&
                     (in_beat_i.line_num >= eff_cfg.first) &&
                     (in_beat_i.line_num <= win_last);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_valid_o <= 1'b0;
      cap_data_o  <= 10'h000;
      cap_line_o  <= 11'h000;
    end else begin
      cap_valid_o <= next_cap_valid;
      cap_data_o  <= in_beat_i.data;
      cap_line_o  <= in_beat_i.line_num;
    end
  end

  // ************************************************************
  // line merge
  // ************************************************************
  logic          ins_line, dup, keep_now, pkt_keep, next_pkt_keep;
  logic          buf_we;
  logic [BW-1:0] wr_cnt, next_wr_cnt, rd_ptr, next_rd_ptr;
  logic [BW-1:0] len_a, len_b, loc_eff;
  logic          a_local, next_a_local, loc_ok, next_loc_ok;
  logic [10:0]   line_num, next_line_num;
  out_beat_s     next_out;

  // insertion line: active, matching line number and a loaded local packet
  assign ins_line = eff_cfg.active && (loc_len != '0) &&
                    (in_beat_i.line_num == service[SVC_LINE_LSB +: 11]);

  anc_dup_match anc_dup_match_inst (
    .en_i       (in_beat_i.pkt_first && ins_line),
    .did_i      (in_beat_i.did),
    .sdid_i     (in_beat_i.sdid),
    .svc_did_i  (service[SVC_DID_LSB +: 8]),
    .svc_sdid_i (service[SVC_SDID_LSB +: 8]),
    .match_o    (dup)
  );

  // keep decision per packet, taken at its first word
  always_comb begin
    keep_now = pkt_keep;
    if (in_beat_i.pkt_first) begin
      if (!ins_line) begin
        keep_now = 1'b1;
      end else if (eff_cfg.pol == POL_OVERWRITE) begin
        keep_now = 1'b0;
      end else if (dup && eff_cfg.local_prio) begin
        keep_now = 1'b0;
      end else begin
        keep_now = 1'b1;
      end
    end
  end

  // second section is dropped whole if it would overflow the line space
  always_comb begin
    loc_eff = loc_ok ? BW'(loc_len) : '0;
    len_a   = a_local ? loc_eff : wr_cnt;
    len_b   = a_local ? wr_cnt : loc_eff;
    if (({1'b0, len_a} + {1'b0, len_b}) > CAP_W) begin
      len_b = '0;
    end
  end

  always_comb begin
    next_state      = state;
    next_wr_cnt     = wr_cnt;
    next_rd_ptr     = rd_ptr;
    next_pkt_keep   = pkt_keep;
    next_a_local    = a_local;
    next_loc_ok     = loc_ok;
    next_line_num   = line_num;
    next_match_seen = match_seen;
    next_ovf        = ovf;
    buf_we          = 1'b0;
    next_out        = '0;
    case (state)
      S_FILL: begin
        if (take && in_beat_i.is_anc) begin
          next_pkt_keep = keep_now;
          if (keep_now && (wr_cnt < DEPTH_W)) begin
            buf_we      = 1'b1;
            next_wr_cnt = wr_cnt + 1'b1;
          end else if (keep_now) begin
            next_ovf = 1'b1;
          end
        end
        if (take && dup) begin
          next_match_seen = 1'b1;
        end
        if (take && in_beat_i.line_last) begin
          next_line_num = in_beat_i.line_num;
          next_a_local  = (eff_cfg.pol == POL_PREPEND);
          // outside overwrite, upstream priority yields to a matching incoming packet
          next_loc_ok   = ins_line && !((eff_cfg.pol != POL_OVERWRITE) &&
                          !eff_cfg.local_prio && (next_match_seen || dup));
          next_rd_ptr   = '0;
          next_state    = S_EMIT_A;
        end
      end
      S_EMIT_A, S_EMIT_B: begin
        if (rd_ptr < ((state == S_EMIT_A) ? len_a : len_b)) begin
          next_out.valid    = 1'b1;
          next_out.is_anc   = 1'b1;
          next_out.line_num = line_num;
          next_out.is_local = (state == S_EMIT_A) == a_local;
          next_out.data     = next_out.is_local ? loc_mem[rd_ptr[LW-2:0]]
                                                : buf_mem[rd_ptr[BW-2:0]];
          next_rd_ptr       = rd_ptr + 1'b1;
        end else begin
          next_rd_ptr = '0;
          next_state  = (state == S_EMIT_A) ? S_EMIT_B : S_MARK;
        end
      end
      S_MARK: begin
        next_out.valid     = 1'b1;
        next_out.line_last = 1'b1;
        next_out.line_num  = line_num;
        next_wr_cnt        = '0;
        next_match_seen    = 1'b0;
        next_state         = S_FILL;
      end
      default: next_state = S_FILL;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= S_FILL;
      wr_cnt     <= '0;
      rd_ptr     <= '0;
      pkt_keep   <= 1'b1;
      a_local    <= 1'b0;
      loc_ok     <= 1'b0;
      line_num   <= 11'h000;
      match_seen <= 1'b0;
      ovf        <= 1'b0;
      out_beat_o <= '0;
    end else begin
      state      <= next_state;
      wr_cnt     <= next_wr_cnt;
      rd_ptr     <= next_rd_ptr;
      pkt_keep   <= next_pkt_keep;
      a_local    <= next_a_local;
      loc_ok     <= next_loc_ok;
      line_num   <= next_line_num;
      match_seen <= next_match_seen;
      ovf        <= next_ovf;
      out_beat_o <= next_out;
    end
  end

  // line buffer for incoming words that survive the keep decision
  always_ff @(posedge core_clk_i) begin
    if (buf_we) begin
      buf_mem[wr_cnt[BW-2:0]] <= in_beat_i.data;
    end
  end

  // status: overflow, match on the line being filled, local inserted, active field setting, format
  assign status_word = {24'h000000, in_fmt_i, cfg.active, loc_ok, match_seen, ovf};

  // ************************************************************
  // menu look
  // ************************************************************
  menu_backdrop menu_backdrop_inst (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .sel_i        (ctrl[CTRL_BD_LSB +: 3]),
    .raster_625_i (ctrl[CTRL_625_BIT]),
    .fmt_i        (in_fmt_i),
    .key_o        (menu_key_o),
    .raster_625_o (menu_raster_standard_o),
    .colour_o     (menu_backdrop_colour_o)
  );

endmodule : vanc_insert_mode_control

// [verification/vid_link_model.sv]
// behavioural upstream source and downstream sink around the video link
module vid_link_model
  import vanc_pkg::*;
(
  // clock
  input  wire logic      core_clk_i,
  // link
  input  wire logic      in_ready_i,
  input  wire out_beat_s out_beat_i,
  output vid_beat_s      in_beat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] out_q[$];   // anc words seen downstream, {is_local, data}
  int          marker_cnt = 0;

  initial in_beat_o = '0;

  // sink never stalls: records anc words and counts line markers
  always @(posedge core_clk_i) begin
    if (out_beat_i.valid && out_beat_i.line_last)
      marker_cnt++;
    else if (out_beat_i.valid && out_beat_i.is_anc)
      out_q.push_back({out_beat_i.is_local, out_beat_i.data});
  end

  // one line of a single anc word; held until taken, then the lines show inverted junk
  task automatic send_line(input logic ff, input logic [10:0] ln, input logic [7:0] did,
                           input logic [7:0] sdid);
    vid_beat_s b;
    vid_beat_s junk;
    int        m;
    b = '{1'b1, ff, 1'b1, 1'b1, 1'b1, ln, did, sdid, 10'h100};
    junk = ~b;
    junk.valid = 1'b0;
    m = marker_cnt;
    in_beat_o <= b;
    @(posedge core_clk_i);
    while (!in_ready_i)
      @(posedge core_clk_i);
    in_beat_o <= junk;
    // the line is over once its marker beat has gone by
    for (int i = 0; i < 300 && marker_cnt == m; i++)
      @(posedge core_clk_i);
  endtask : send_line
endmodule : vid_link_model

// [verification/vanc_insert_mode_control_properties.sv]
// concurrent checks on the ports of the vanc insert control
module vanc_insert_mode_control_properties
  import vanc_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // watched ports
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire vid_beat_s   in_beat_i,
  input wire fmt_e        in_fmt_i,
  input wire logic        in_ready_o,
  input wire out_beat_s   out_beat_o,
  input wire logic        cap_valid_o,
  input wire logic [9:0]  cap_data_o,
  input wire logic [10:0] cap_line_o,
  input wire logic        menu_key_o,
  input wire logic [29:0] menu_backdrop_colour_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dflt @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // helpers: end of an incoming line, and the vertical interval ceiling of the format
  logic        take_last;
  logic [10:0] vi_lim;
  assign take_last = in_beat_i.valid && in_ready_o && in_beat_i.line_last;
  assign vi_lim = (in_fmt_i == FMT_720P_50 || in_fmt_i == FMT_720P_5994 ||
                   in_fmt_i == FMT_1080SF_2398) ? WIN_LAST_PROG : WIN_LAST_STD;

  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read answer");
  a_ready_drop_line: assert property (take_last |=> !in_ready_o ##1 !in_ready_o)
    else $error("ready stayed up after line end");
  a_emit_gap_first: assert property (take_last |=> !out_beat_o.valid)
    else $error("output beat too early after line end");
  a_line_closed: assert property (take_last |-> ##[3:400] (out_beat_o.valid && out_beat_o.line_last))
    else $error("line marker missing");
  a_marker_form: assert property (out_beat_o.valid && out_beat_o.line_last |->
                                  !out_beat_o.is_anc && !out_beat_o.is_local)
    else $error("line marker carries anc or local flag");
  a_cap_source: assert property (cap_valid_o |-> $past(in_beat_i.valid && in_ready_o &&
      in_beat_i.is_anc) && cap_data_o == $past(in_beat_i.data) &&
      cap_line_o == $past(in_beat_i.line_num))
    else $error("captured word has no taken anc source");
  a_cap_vi_limit: assert property (cap_valid_o |-> cap_line_o <= $past(vi_lim))
    else $error("capture beyond vertical interval");
  a_key_sd_only: assert property (menu_key_o |->
      $past(in_fmt_i == FMT_480I_5994 || in_fmt_i == FMT_576I_50))
    else $error("menu keyed without sd input");
  a_key_black: assert property (menu_key_o |-> menu_backdrop_colour_o == YCC_BLACK)
    else $error("keyed backdrop not black");
endmodule : vanc_insert_mode_control_properties

bind vanc_insert_mode_control vanc_insert_mode_control_properties
  vanc_insert_mode_control_properties_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .in_beat_i(in_beat_i), .in_fmt_i(in_fmt_i),
  .in_ready_o(in_ready_o), .out_beat_o(out_beat_o), .cap_valid_o(cap_valid_o),
  .cap_data_o(cap_data_o), .cap_line_o(cap_line_o), .menu_key_o(menu_key_o),
  .menu_backdrop_colour_o(menu_backdrop_colour_o));

// [verification/vanc_insert_mode_control_tb_top.sv]
// testbench: register port, line merge policies, capture window and menu look
module vanc_insert_mode_control_tb_top import vanc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam logic [10:0] INC = 11'h100;   // incoming word as seen downstream
  localparam logic [10:0] LOC = 11'h6A5;   // local word, is_local set
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cap_valid, key, raster, in_ready;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [9:0] cap_data;
  logic [10:0] cap_line;
  logic [29:0] colour;
  vid_beat_s in_beat;
  out_beat_s out_beat;
  fmt_e fmt = FMT_1080I_5994;
  int errors = 0, total_checks = 0, cycles = 0, cap_cnt = 0;

  always #2.5 clk = ~clk;

  vanc_insert_mode_control vanc_insert_mode_control_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .in_beat_i(in_beat),
    .in_fmt_i(fmt), .in_ready_o(in_ready), .out_beat_o(out_beat), .cap_valid_o(cap_valid),
    .cap_data_o(cap_data), .cap_line_o(cap_line), .menu_key_o(key),
    .menu_raster_standard_o(raster), .menu_backdrop_colour_o(colour));
  vid_link_model vid_link_model_inst (
    .core_clk_i(clk), .in_ready_i(in_ready), .out_beat_i(out_beat), .in_beat_o(in_beat));

  // capture pulse count and hang guard; a run needs a few hundred cycles at most
  always @(posedge clk) begin
    cycles++;
    if (cap_valid)
      cap_cnt++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : reg_read

  // one line of one incoming word, then count and first two downstream words
  task automatic line(input string what, input logic ff, input logic [10:0] ln,
                      input logic [7:0] did, input int n, input logic [10:0] w0,
                      input logic [10:0] w1);
    vid_link_model_inst.out_q.delete();
    vid_link_model_inst.send_line(ff, ln, did, (did == 8'h41) ? 8'h05 : 8'h02);
    check(what, vid_link_model_inst.out_q.size(), n);
    if (n > 0)
      check(what, vid_link_model_inst.out_q[0], w0);
    if (n > 1)
      check(what, vid_link_model_inst.out_q[1], w1);
  endtask : line

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [31:0] d;
    reg_read(OFS_CTRL, d);
    check("ctrl reset", d, 32'h0000_0001);
    reg_read(OFS_WINDOW, d);
    check("window reset", d, 32'h0014_0001);
    reg_read(OFS_SERVICE, d);
    check("service reset", d, 32'h0009_0000);
    reg_read(8'h1C, d);
    check("unmapped read", d, 32'h0);
    reg_write(OFS_LABEL, 32'hA5A5_5A5A);
    reg_read(OFS_LABEL, d);
    check("label", d, 32'hA5A5_5A5A);
    check("backdrop reset", colour, YCC_BLACK);
    reg_read(OFS_STATUS, d);
    check("status idle", d, 32'h0000_0060);
    // local service: did 41, sdid 05 on line 9, one word
    reg_write(OFS_SERVICE, 32'h0009_0541);
    reg_write(OFS_LENGTH, 32'h1);
    reg_write(OFS_LOAD, 32'h0000_02A5);
  endtask : t_regs

  task automatic t_modes();
    line("append", 1'b1, 11'd9, 8'h61, 2, INC, LOC);
    reg_write(OFS_CTRL, 32'h3);
    line("prepend", 1'b1, 11'd9, 8'h61, 2, LOC, INC);
    reg_write(OFS_CTRL, 32'h5);
    line("overwrite", 1'b1, 11'd9, 8'h61, 1, LOC, '0);
    line("untouched line", 1'b1, 11'd12, 8'h61, 1, INC, '0);
    reg_write(OFS_CTRL, 32'h0);
    line("bypass", 1'b1, 11'd9, 8'h61, 1, INC, '0);
  endtask : t_modes

  // matching incoming packet under each policy, with both priorities for append and prepend
  task automatic t_dup();
    logic [31:0] ctl[5] = '{32'h1, 32'h9, 32'h3, 32'hB, 32'h5};
    logic [10:0] exp[5] = '{INC, LOC, INC, LOC, LOC};
    foreach (ctl[i]) begin
      reg_write(OFS_CTRL, ctl[i]);
      line("duplicate", 1'b1, 11'd9, 8'h41, 1, exp[i], '0);
    end
  endtask : t_dup

  // a policy change waits for the next field start
  task automatic t_freeze();
    reg_write(OFS_CTRL, 32'h3);
    line("mid field", 1'b0, 11'd9, 8'h61, 1, LOC, '0);
    line("next field", 1'b1, 11'd9, 8'h61, 2, LOC, INC);
  endtask : t_freeze

  task automatic cap(input fmt_e f, input logic [10:0] ln, input int n);
    int c;
    fmt <= f;
    c = cap_cnt;
    line("capture line", 1'b1, ln, 8'h61, 1, INC, '0);
    check("capture count", cap_cnt - c, n);
  endtask : cap

  task automatic t_capture();
    reg_write(OFS_WINDOW, 32'h0019_0001);
    cap(FMT_1080I_5994, 11'd20, 1);
    cap(FMT_1080I_5994, 11'd22, 0);
    cap(FMT_720P_50, 11'd25, 1);
    cap(FMT_1080SF_2398, 11'd25, 1);
    cap(FMT_720P_50, 11'd26, 0);
  endtask : t_capture

  task automatic t_menu();
    logic [29:0] ycc[4] = '{YCC_BLACK, YCC_GREY, YCC_WHITE, YCC_BLUE};
    fmt_e        f[4] = '{FMT_480I_5994, FMT_576I_50, FMT_1080I_50, FMT_NONE};
    reg_write(OFS_CTRL, 32'h11);
    @(posedge clk) check("raster 625", raster, 1'b1);
    reg_write(OFS_CTRL, 32'h1);
    @(posedge clk) check("raster 525", raster, 1'b0);
    for (int i = 0; i < 4; i++) begin
      reg_write(OFS_CTRL, 32'h1 | (i << 5));
      @(posedge clk) check("backdrop", colour, ycc[i]);
    end
    reg_write(OFS_CTRL, 32'h81);
    for (int i = 0; i < 4; i++) begin
      fmt <= f[i];
      repeat (2) @(posedge clk);
      check("overlay key", key, i < 2);
      check("overlay colour", colour, YCC_BLACK);
    end
  endtask : t_menu

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_dup();
    t_freeze();
    t_capture();
    t_menu();
    test_done();
  end
endmodule : vanc_insert_mode_control_tb_top
